/* File: include/fcs_defines.svh */
`ifndef FCS_DEFINES_SVH
`define FCS_DEFINES_SVH

// Register indexes; byte address is four times the index
`define FCS_IDX_DIVIDER 10'h100
`define FCS_IDX_CONFIG 10'h103
`define FCS_IDX_STATUS 10'h105
`define FCS_IDX_COMMAND 10'h106
`define FCS_IDX_RESERVED 10'h107
`define FCS_IDX_ADDR_HI 10'h108
`define FCS_IDX_ADDR_LO 10'h109
`define FCS_IDX_DATA_HI 10'h10A
`define FCS_IDX_DATA_LO 10'h10B
`define FCS_IDX_WORD_ADDR 10'h110
`define FCS_IDX_WORD_DATA 10'h111

// Status bit positions
`define FCS_ST_BUF_EMPTY 7
`define FCS_ST_CMD_DONE 6
`define FCS_ST_PROT_VIOL 5
`define FCS_ST_ACC_ERR 4
`define FCS_ST_BLANK 2

// Divider and config bit positions
`define FCS_DIV_LOADED 7
`define FCS_DIV_PRESCALE 6
`define FCS_CFG_BUF_IE 7
`define FCS_CFG_DONE_IE 6

// Masks
`define FCS_CMD_MASK 8'h65
`define FCS_ADDR_HI_MASK 8'h7F
`define FCS_SECTOR_MASK 16'hFE00

// Command codes
`define FCS_CMD_ERASE_VERIFY 8'h05
`define FCS_CMD_PROGRAM 8'h20
`define FCS_CMD_SECTOR_ERASE 8'h40
`define FCS_CMD_MASS_ERASE 8'h41

// Prescaler terminal count, divide by eight
`define FCS_PRESCALE_LAST 3'h7

`endif

/* File: include/fcs_pkg.sv */
package fcs_pkg;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_GOT_WORD,
    SEQ_GOT_CMD
  } fcs_seq_type;

  typedef struct packed {
    logic [7:0] cmd;
    logic [1:0] bank;
    logic [15:0] addr;
    logic [15:0] data;
  } fcs_entry_type;

endpackage : fcs_pkg

/* File: core/fcs_core.sv */
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "fcs_defines.svh"
// Behaviour
// - Writing one to buffer-empty launches command
// - Writing zero sets access error, aborts sequence
// - Buffer-empty high exactly when buffer stage free
// - Interrupt from flag and enable pairs
// - Command-complete only when nothing active or pending
// - Command-complete stays low on pending fetch
// - Protection violation set on protected target, except erase verify
// - Protection violation anywhere blocks all launches
// - Access error on bad sequence, code, stop
// - Access error write-one-clear, blocks all launches
// - Blank set by verify, cleared on launch
// - Status bits 3, 1, 0 read zero
// - Four legal command codes, others error
// - Command bits 7,4,3,1 read zero
// - Address buffer visible only in special mode
// - Sector erase drops low nine address bits
// - Data buffer visible only in special mode
// - Two-stage command pipeline
// - Divider write sets loaded flag, gates commands
// - Optional divide by eight before divider
// - Two-bit bank select, bank zero after reset
module fcs_core (
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic special_mode_pin, // Special mode strap, async
  input wire logic stop_req_pin, // CPU stop request, async
  input wire logic osc_clk_pin, // Oscillator clock, async
  input wire logic [3:0] protect_bank, // Per-block protection active
  input wire logic array_done, // Array finished active command
  input wire logic array_blank, // Erase verify result
  output logic irq, // Interrupt request
  output logic timebase_tick, // Algorithm timebase pulse
  output logic array_start, // Start pulse for active command
  output fcs_pkg::fcs_entry_type array_req // Active command
);

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers and bus decode
  logic [1:0] spec_sync_reg, stop_sync_reg, osc_sync_reg;
  logic osc_prev_reg;
  logic special_mode, stop_req, osc_rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spec_sync_reg <= 2'h0;
      stop_sync_reg <= 2'h0;
      osc_sync_reg <= 2'h0;
      osc_prev_reg <= 1'h0;
    end else begin
      spec_sync_reg <= {spec_sync_reg[0], special_mode_pin};
      stop_sync_reg <= {stop_sync_reg[0], stop_req_pin};
      osc_sync_reg <= {osc_sync_reg[0], osc_clk_pin};
      osc_prev_reg <= osc_sync_reg[1];
    end
  end

  assign special_mode = spec_sync_reg[1];
  assign stop_req = stop_sync_reg[1];
  assign osc_rise = osc_sync_reg[1] && !osc_prev_reg;

  logic wr;
  logic [9:0] idx;
  logic mapped;
  assign idx = paddr[11:2];
  assign wr = psel && penable && pwrite && pready;
  always_comb begin
    case (idx)
      `FCS_IDX_DIVIDER, `FCS_IDX_CONFIG, `FCS_IDX_STATUS, `FCS_IDX_COMMAND,
      `FCS_IDX_RESERVED, `FCS_IDX_ADDR_HI, `FCS_IDX_ADDR_LO, `FCS_IDX_DATA_HI,
      `FCS_IDX_DATA_LO, `FCS_IDX_WORD_ADDR, `FCS_IDX_WORD_DATA: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Divider, config and word address registers
  logic div_loaded_reg, prescale_reg;
  logic [5:0] div_ratio_reg;
  logic buf_ie_reg, done_ie_reg;
  logic [1:0] bank_sel_reg;
  logic [15:0] word_addr_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_loaded_reg <= 1'b0;
      prescale_reg <= 1'b0;
      div_ratio_reg <= 6'h00;
    end else if (wr && idx == `FCS_IDX_DIVIDER) begin
      div_loaded_reg <= 1'b1;
      prescale_reg <= pwdata[`FCS_DIV_PRESCALE];
      div_ratio_reg <= pwdata[5:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_ie_reg <= 1'b0;
      done_ie_reg <= 1'b0;
      bank_sel_reg <= 2'h0;
      word_addr_reg <= 16'h0000;
    end else if (wr && idx == `FCS_IDX_CONFIG) begin
      buf_ie_reg <= pwdata[`FCS_CFG_BUF_IE];
      done_ie_reg <= pwdata[`FCS_CFG_DONE_IE];
      bank_sel_reg <= pwdata[1:0];
    end else if (wr && idx == `FCS_IDX_WORD_ADDR) begin
      word_addr_reg <= pwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Algorithm timebase
  logic [2:0] pre_cnt_reg;
  logic [5:0] div_cnt_reg;
  logic pre_tick;
  assign pre_tick = osc_rise && (!prescale_reg || pre_cnt_reg == `FCS_PRESCALE_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_reg <= 3'h0;
      div_cnt_reg <= 6'h00;
      timebase_tick <= 1'b0;
    end else begin
      timebase_tick <= 1'b0;
      if (osc_rise) begin
        pre_cnt_reg <= pre_cnt_reg + 3'h1;
      end
      if (pre_tick) begin
        if (div_cnt_reg >= div_ratio_reg) begin
          div_cnt_reg <= 6'h00;
          timebase_tick <= div_loaded_reg; // No timebase until divider set
        end else begin
          div_cnt_reg <= div_cnt_reg + 6'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command sequence events
  fcs_pkg::fcs_seq_type seq_reg;
  fcs_pkg::fcs_entry_type stage_reg, act_reg;
  logic buf_valid_reg, act_valid_reg;
  logic [3:0] acc_err_reg, prot_viol_reg, blank_reg;
  logic buf_empty, cmd_done, any_lock, cmd_legal;
  logic ev_word, ev_cmd, ev_stat, launch_req, abort_zero;
  logic err_seq, acc_ev, prot_ev, launch_ok, kill;

  assign buf_empty = !buf_valid_reg;
  assign cmd_done = !buf_valid_reg && !act_valid_reg;
  assign any_lock = (|acc_err_reg) || (|prot_viol_reg);
  assign ev_word = wr && idx == `FCS_IDX_WORD_DATA;
  assign ev_cmd = wr && idx == `FCS_IDX_COMMAND;
  assign ev_stat = wr && idx == `FCS_IDX_STATUS;
  assign launch_req = ev_stat && pwdata[`FCS_ST_BUF_EMPTY];
  assign abort_zero = ev_stat && !pwdata[`FCS_ST_BUF_EMPTY];

  always_comb begin
    case (pwdata[7:0])
      `FCS_CMD_ERASE_VERIFY, `FCS_CMD_PROGRAM,
      `FCS_CMD_SECTOR_ERASE, `FCS_CMD_MASS_ERASE: cmd_legal = 1'b1;
      default: cmd_legal = 1'b0;
    endcase
  end

  // Writes outside the strict word, command, launch order abort the sequence
  always_comb begin
    err_seq = 1'b0;
    if (ev_word && (seq_reg != fcs_pkg::SEQ_IDLE || !buf_empty || !div_loaded_reg
        || word_addr_reg[0])) begin
      err_seq = 1'b1;
    end
    if (ev_cmd && (seq_reg != fcs_pkg::SEQ_GOT_WORD || !cmd_legal)) begin
      err_seq = 1'b1;
    end
    if (wr && seq_reg == fcs_pkg::SEQ_GOT_WORD && !ev_cmd && !ev_word) begin
      err_seq = 1'b1;
    end
    if (wr && seq_reg == fcs_pkg::SEQ_GOT_CMD && !ev_stat) begin
      err_seq = 1'b1;
    end
  end

  assign kill = stop_req && !cmd_done;
  assign acc_ev = err_seq || abort_zero || kill;
  // Locked launches are held, not errored, so software can clear and retry
  assign prot_ev = launch_req && seq_reg == fcs_pkg::SEQ_GOT_CMD && !any_lock && !kill
                   && stage_reg.cmd != `FCS_CMD_ERASE_VERIFY
                   && protect_bank[stage_reg.bank];
  assign launch_ok = launch_req && seq_reg == fcs_pkg::SEQ_GOT_CMD && !any_lock && !kill
                     && div_loaded_reg && !prot_ev;

  ////////////////////////////////////////////////////////////////////////
  // Two-stage pipeline: buffer stage and active stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_reg <= fcs_pkg::SEQ_IDLE;
      stage_reg <= '0;
      buf_valid_reg <= 1'b0;
    end else begin
      if (acc_ev || prot_ev) begin
        seq_reg <= fcs_pkg::SEQ_IDLE;
      end else if (ev_word) begin
        seq_reg <= fcs_pkg::SEQ_GOT_WORD;
        stage_reg.addr <= word_addr_reg;
        stage_reg.data <= pwdata[15:0];
        stage_reg.bank <= bank_sel_reg;
      end else if (ev_cmd) begin
        seq_reg <= fcs_pkg::SEQ_GOT_CMD;
        stage_reg.cmd <= pwdata[7:0] & `FCS_CMD_MASK;
      end else if (launch_ok) begin
        seq_reg <= fcs_pkg::SEQ_IDLE;
        if (stage_reg.cmd == `FCS_CMD_SECTOR_ERASE) begin
          stage_reg.addr <= stage_reg.addr & `FCS_SECTOR_MASK;
        end
      end else if (special_mode && wr && seq_reg == fcs_pkg::SEQ_IDLE) begin
        if (idx == `FCS_IDX_ADDR_HI) begin
          stage_reg.addr[15:8] <= pwdata[7:0] & `FCS_ADDR_HI_MASK;
        end
        if (idx == `FCS_IDX_ADDR_LO) begin
          stage_reg.addr[7:0] <= pwdata[7:0];
        end
      end
      if (kill) begin
        buf_valid_reg <= 1'b0;
      end else if (launch_ok) begin
        buf_valid_reg <= 1'b1;
      end else if (buf_valid_reg && (!act_valid_reg || array_done)) begin
        buf_valid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_reg <= '0;
      act_valid_reg <= 1'b0;
      array_start <= 1'b0;
    end else begin
      array_start <= 1'b0;
      if (kill) begin
        act_valid_reg <= 1'b0;
      end else if (buf_valid_reg && (!act_valid_reg || array_done)) begin
        act_reg <= stage_reg;
        act_valid_reg <= 1'b1;
        array_start <= 1'b1;
      end else if (array_done) begin
        act_valid_reg <= 1'b0;
      end
    end
  end

  assign array_req = act_reg;

  ////////////////////////////////////////////////////////////////////////
  // Banked status flags; hardware set wins over software clear
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_bank
      logic sel_clr;
      assign sel_clr = ev_stat && bank_sel_reg == 2'(b);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          acc_err_reg[b] <= 1'b0;
          prot_viol_reg[b] <= 1'b0;
          blank_reg[b] <= 1'b0;
        end else begin
          if (acc_ev && bank_sel_reg == 2'(b)) begin
            acc_err_reg[b] <= 1'b1;
          end else if (sel_clr && pwdata[`FCS_ST_ACC_ERR]) begin
            acc_err_reg[b] <= 1'b0;
          end
          if (prot_ev && stage_reg.bank == 2'(b)) begin
            prot_viol_reg[b] <= 1'b1;
          end else if (sel_clr && pwdata[`FCS_ST_PROT_VIOL]) begin
            prot_viol_reg[b] <= 1'b0;
          end
          if (act_valid_reg && array_done && act_reg.bank == 2'(b)
              && act_reg.cmd == `FCS_CMD_ERASE_VERIFY && array_blank) begin
            blank_reg[b] <= 1'b1;
          end else if (launch_ok && stage_reg.bank == 2'(b)) begin
            blank_reg[b] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // APB answer, no wait states, and interrupt
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      `FCS_IDX_DIVIDER: rd_byte = {div_loaded_reg, prescale_reg, div_ratio_reg};
      `FCS_IDX_CONFIG: rd_byte = {buf_ie_reg, done_ie_reg, 4'h0, bank_sel_reg};
      `FCS_IDX_STATUS: begin
        rd_byte[`FCS_ST_BUF_EMPTY] = buf_empty;
        rd_byte[`FCS_ST_CMD_DONE] = cmd_done;
        rd_byte[`FCS_ST_PROT_VIOL] = prot_viol_reg[bank_sel_reg];
        rd_byte[`FCS_ST_ACC_ERR] = acc_err_reg[bank_sel_reg];
        rd_byte[`FCS_ST_BLANK] = blank_reg[bank_sel_reg];
      end
      `FCS_IDX_COMMAND: rd_byte = stage_reg.cmd & `FCS_CMD_MASK;
      `FCS_IDX_ADDR_HI: rd_byte = special_mode ? stage_reg.addr[15:8] : 8'h00;
      `FCS_IDX_ADDR_LO: rd_byte = special_mode ? stage_reg.addr[7:0] : 8'h00;
      `FCS_IDX_DATA_HI: rd_byte = special_mode ? stage_reg.data[15:8] : 8'h00;
      `FCS_IDX_DATA_LO: rd_byte = special_mode ? stage_reg.data[7:0] : 8'h00;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) begin
        prdata <= {24'h000000, rd_byte};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (buf_empty && buf_ie_reg) || (cmd_done && done_ie_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  chk_abort_sets_err: assert property (@(posedge pclk) disable iff (!presetn)
    abort_zero |=> acc_err_reg[$past(bank_sel_reg)] && seq_reg == fcs_pkg::SEQ_IDLE)
    else $error("zero write to buffer-empty did not abort");
  chk_launch_fills: assert property (@(posedge pclk) disable iff (!presetn)
    launch_ok |=> !buf_empty && !cmd_done)
    else $error("launch did not occupy buffer");
  chk_lock_blocks: assert property (@(posedge pclk) disable iff (!presetn)
    any_lock && !buf_valid_reg |=> !buf_valid_reg)
    else $error("launch while error flag set");
  chk_done_empty: assert property (@(posedge pclk) disable iff (!presetn)
    act_valid_reg && array_done && buf_valid_reg && !kill |=> !cmd_done)
    else $error("command complete while buffer busy");
  chk_fetch_start: assert property (@(posedge pclk) disable iff (!presetn)
    (buf_valid_reg && !act_valid_reg && !kill) |=> array_start ##1 !array_start)
    else $error("pending command not fetched");
  chk_illegal_code: assert property (@(posedge pclk) disable iff (!presetn)
    (ev_cmd && !cmd_legal) |=> acc_err_reg[$past(bank_sel_reg)])
    else $error("illegal code not flagged");
  chk_no_div_word: assert property (@(posedge pclk) disable iff (!presetn)
    (ev_word && !div_loaded_reg) |=> seq_reg == fcs_pkg::SEQ_IDLE)
    else $error("word accepted before divider set");
  chk_sector_mask: assert property (@(posedge pclk) disable iff (!presetn)
    array_start && act_reg.cmd == `FCS_CMD_SECTOR_ERASE |-> act_reg.addr[8:0] == 9'h000)
    else $error("sector address low bits kept");
  chk_irq_done: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_done && done_ie_reg) |=> irq)
    else $error("missing interrupt");
  cov_launch: cover property (@(posedge pclk) disable iff (!presetn) launch_ok);
  cov_pipelined: cover property (@(posedge pclk) disable iff (!presetn)
    act_valid_reg && buf_valid_reg);
  cov_prot: cover property (@(posedge pclk) disable iff (!presetn) prot_ev);
  cov_blank: cover property (@(posedge pclk) disable iff (!presetn) |blank_reg);

endmodule : fcs_core

/* File: bench/fcs_array_model.sv */
`timescale 1ns/1ps
module fcs_array_model (
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Reset, active low
  input wire logic array_start, // Command start pulse
  input wire logic [7:0] lat, // Cycles each command takes
  input wire logic blank_in, // Verify outcome to report
  output logic array_done, // Finish pulse
  output logic array_blank // Verify result
);
  logic [7:0] cnt_reg;
  logic busy_reg;
  logic toggle_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
      cnt_reg <= 8'h00;
      array_done <= 1'b0;
    end else begin
      array_done <= 1'b0;
      if (array_start) begin
        busy_reg <= 1'b1;
        cnt_reg <= lat;
      end else if (busy_reg) begin
        if (cnt_reg == 8'h00) begin
          busy_reg <= 1'b0;
          array_done <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 8'h01;
        end
      end
    end
  end

  // Result only meaningful with done; otherwise keep it moving
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      toggle_reg <= 1'b0;
    end else begin
      toggle_reg <= ~toggle_reg;
    end
  end

  assign array_blank = array_done ? blank_in : toggle_reg;
endmodule : fcs_array_model

/* File: bench/fcs_core_tb.sv */
`timescale 1ns/1ps
`include "fcs_defines.svh"
module fcs_core_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, blank_in;
  logic special_mode_pin, stop_req_pin, osc_clk_pin, timebase_tick;
  logic array_start, array_done, array_blank, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] protect_bank;
  logic [7:0] lat;
  fcs_pkg::fcs_entry_type array_req, got;
  int n_errors, compares, ticks;
  localparam logic [9:0] r_st = `FCS_IDX_STATUS;
  localparam logic [9:0] r_cmd = `FCS_IDX_COMMAND;
  localparam logic [9:0] r_cfg = `FCS_IDX_CONFIG;
  localparam logic [9:0] r_div = `FCS_IDX_DIVIDER;

  fcs_core i_fcs_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .special_mode_pin(special_mode_pin), .stop_req_pin(stop_req_pin),
    .osc_clk_pin(osc_clk_pin), .protect_bank(protect_bank), .array_done(array_done),
    .array_blank(array_blank), .irq(irq), .timebase_tick(timebase_tick),
    .array_start(array_start), .array_req(array_req));
  fcs_array_model i_fcs_array_model (.pclk(pclk), .presetn(presetn),
    .array_start(array_start), .lat(lat), .blank_in(blank_in),
    .array_done(array_done), .array_blank(array_blank));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    osc_clk_pin = 1'b0;
    forever #40 osc_clk_pin = ~osc_clk_pin;
  end
  always @(posedge pclk) if (timebase_tick === 1'b1) ticks++;
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (n_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Request held until pready is seen high at an edge
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [15:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {16'h0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so a following call never reassigns psel in this time step
    @(posedge pclk);
  endtask : bus

  task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp, input string what);
    bus(1'b0, idx, 16'h0000);
    chk(what, exp, rd);
  endtask : rdchk

  task automatic seq(input logic [15:0] a, input logic [15:0] d, input logic [7:0] c);
    bus(1'b1, `FCS_IDX_WORD_ADDR, a);
    bus(1'b1, `FCS_IDX_WORD_DATA, d);
    bus(1'b1, r_cmd, {8'h00, c});
    bus(1'b1, r_st, 16'h0080);
  endtask : seq

  task automatic wait_start();
    int i;
    i = 0;
    while (array_start !== 1'b1 && i < 100) begin
      @(posedge pclk);
      i++;
    end
    got = array_req;
    chk("array start", 32'h1, {31'h0, array_start});
  endtask : wait_start

  task automatic wait_done(input logic [31:0] exp, input string what);
    int i;
    i = 0;
    rd = 32'h0;
    while (rd[6] !== 1'b1 && i < 100) begin
      bus(1'b0, r_st, 16'h0000);
      i++;
    end
    chk(what, exp, rd);
  endtask : wait_done

  // Clear access error and protection violation flags; bit 7 kept high so no abort is signalled
  task automatic clr();
    bus(1'b1, r_st, 16'h00BF);
    rdchk(r_st, 32'hC0, "status after clear");
  endtask : clr

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    n_errors = 0;
    compares = 0;
    ticks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    special_mode_pin = 1'b0;
    stop_req_pin = 1'b0;
    protect_bank = 4'h0;
    lat = 8'h04;
    blank_in = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(r_st, 32'hC0, "status after reset");
    rdchk(r_div, 32'h0, "divider after reset");
    rdchk(r_cfg, 32'h0, "bank after reset");
    rdchk(`FCS_IDX_ADDR_HI, 32'h0, "address user mode");
    rdchk(`FCS_IDX_DATA_LO, 32'h0, "data user mode");
    bus(1'b0, 10'h3FF, 16'h0000);
    chk("unmapped error", 32'h1, {31'h0, err});
    seq(16'h1000, 16'h1234, `FCS_CMD_PROGRAM);
    rdchk(r_st, 32'hD0, "error without divider");
    clr();
    chk("ticks before load", 32'h0, ticks);
    // Oscillator 12.5 MHz, divide by 8 then by 10 gives about 156 kHz
    bus(1'b1, r_div, 16'h0049);
    rdchk(r_div, 32'hC9, "divider loaded");
    repeat (900) @(posedge pclk);
    chk("ticks after load", 32'h1, {31'h0, ticks > 0});
    lat <= 8'd40;
    seq(16'h2002, 16'hBEEF, `FCS_CMD_PROGRAM);
    wait_start();
    chk("request", 32'h2002BEEF, 32'(got));
    chk("request cmd", 32'h20, 32'(got.cmd));
    rdchk(r_st, 32'h80, "running");
    seq(16'h4320, 16'h0000, `FCS_CMD_SECTOR_ERASE);
    rdchk(r_st, 32'h00, "pending held");
    wait_start();
    rdchk(r_st, 32'h80, "fetch keeps complete low");
    chk("sector address", 32'h4200, 32'(got.addr));
    wait_done(32'hC0, "both finished");
    lat <= 8'd4;
    blank_in <= 1'b1;
    seq(16'h0000, 16'h0000, `FCS_CMD_ERASE_VERIFY);
    wait_done(32'hC4, "blank after verify");
    seq(16'h0100, 16'h0000, `FCS_CMD_MASS_ERASE);
    wait_start();
    chk("mass cmd", 32'h41, 32'(got.cmd));
    wait_done(32'hC0, "blank cleared on launch");
    bus(1'b1, `FCS_IDX_WORD_ADDR, 16'h0010);
    bus(1'b1, `FCS_IDX_WORD_DATA, 16'h5555);
    bus(1'b1, r_cmd, 16'h00FF);
    rdchk(r_st, 32'hD0, "illegal code");
    clr();
    bus(1'b1, `FCS_IDX_WORD_ADDR, 16'h0010);
    bus(1'b1, `FCS_IDX_WORD_DATA, 16'h5555);
    bus(1'b1, r_cmd, 16'h0020);
    rdchk(r_cmd, 32'h20, "command readback");
    bus(1'b1, r_st, 16'h0000);
    rdchk(r_st, 32'hD0, "abort by zero");
    clr();
    protect_bank <= 4'h1;
    seq(16'h0200, 16'h0001, `FCS_CMD_PROGRAM);
    rdchk(r_st, 32'hE0, "protected target");
    clr();
    protect_bank <= 4'h0;
    lat <= 8'd40;
    seq(16'h0300, 16'h0002, `FCS_CMD_PROGRAM);
    wait_start();
    stop_req_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    bus(1'b0, r_st, 16'h0000);
    chk("stop while busy", 32'h10, rd & 32'h10);
    stop_req_pin <= 1'b0;
    repeat (45) @(posedge pclk);
    clr();
    special_mode_pin <= 1'b1;
    repeat (3) @(posedge pclk);
    bus(1'b1, `FCS_IDX_ADDR_HI, 16'h00FF);
    rdchk(`FCS_IDX_ADDR_HI, 32'h7F, "address high special");
    bus(1'b1, `FCS_IDX_ADDR_LO, 16'h0034);
    rdchk(`FCS_IDX_ADDR_LO, 32'h34, "address low special");
    rdchk(`FCS_IDX_DATA_LO, 32'h02, "data special");
    special_mode_pin <= 1'b0;
    repeat (3) @(posedge pclk);
    bus(1'b1, r_cfg, 16'h0080);
    repeat (3) @(posedge pclk);
    chk("irq buffer empty", 32'h1, {31'h0, irq});
    bus(1'b1, r_cfg, 16'h0043);
    repeat (3) @(posedge pclk);
    chk("irq complete", 32'h1, {31'h0, irq});
    bus(1'b1, r_cfg, 16'h0003);
    repeat (3) @(posedge pclk);
    chk("irq off", 32'h0, {31'h0, irq});
    rdchk(r_cfg, 32'h03, "bank select");
    rdchk(r_st, 32'hC0, "bank three status");
    print_verdict();
  end
endmodule : fcs_core_tb
